// file: tcpwm_top.v
// What this block does
// - Each instance holds a 16-bit counter that only counts down.
// - Four identical instances each drive a compare output, a terminal count output and an interrupt line.
// - Each instance can drive a complementary PWM pair with a deadband gap, the complement being optional.
// - Each instance runs free, runs one period, or counts only under an external enable input.
// - In one-shot mode the counter reloads the period at the end of its period and then halts instead of going on.
// - In gated mode the counter decrements only in cycles where the enable input is high and holds otherwise.
// - Each instance takes counter reset, capture and kill inputs, and kill forces the compare outputs inactive.
// - A capture event latches the full 16-bit counter value into the capture register.
// - The comparator asserts its output for a selectable relation: less, less-or-equal, equal, greater-or-equal, greater.
// - The counter loads the period value on start, on reset and at terminal count.
// - The interrupt can be raised by terminal count, compare true or capture, each source selectable.
// - Each instance takes its counting clock from one of several selectable sources.
`timescale 1ns/1ps
`include "tcpwm_regs.vh"

module tcpwm_top (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// ahb-lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output wire [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// routing inputs, one bit per instance, asynchronous
	input wire [3:0] ext_clk_in,
	input wire [3:0] count_en_in,
	input wire [3:0] cnt_reset_in,
	input wire [3:0] capture_in,
	input wire [3:0] kill_in,
	// routing outputs, one bit per instance
	output wire [3:0] compare_out,
	output wire [3:0] compare_n_out,
	output wire [3:0] tc_out,
	output wire [3:0] irq_out
);

	function sel_hit;
		input [11:0] addr;
		input [31:0] ch;
		input [4:0] off;
		begin
			sel_hit = (addr[11:7] == 5'h00) && (addr[`TCPWM_CH_MSB:`TCPWM_CH_LSB] == ch[1:0]) &&
				(addr[4:0] == off);
		end
	endfunction

	function rel_true;
		input [15:0] cnt;
		input [15:0] cmp;
		input [2:0] rel;
		begin
			case (rel)
				`TCPWM_REL_LESS: rel_true = cnt < cmp;
				`TCPWM_REL_LESS_OR_EQUAL: rel_true = cnt <= cmp;
				`TCPWM_REL_MATCH_SAME: rel_true = cnt == cmp;
				`TCPWM_REL_GREATER_OR_SAME: rel_true = cnt >= cmp;
				`TCPWM_REL_GREATER: rel_true = cnt > cmp;
				default: rel_true = 1'b0;
			endcase
		end
	endfunction

	// bus state
	reg wr_q;
	reg [11:0] waddr_q;
	reg [31:0] hrdata_q;
	reg [31:0] rd_d;
	wire addr_phase = hsel && hready && htrans[1];

	// exported per-instance state for the read mux
	wire [`TCPWM_CTRL_W-1:0] ctrl_w [0:3];
	wire [15:0] per_w [0:3];
	wire [15:0] cmpv_w [0:3];
	wire [15:0] cnt_w [0:3];
	wire [15:0] cap_w [0:3];
	wire [7:0] db_w [0:3];
	wire [2:0] st_w [0:3];
	wire [2:0] msk_w [0:3];

	// input synchronisers and edge history
	reg [3:0] ext_s1_q, ext_s2_q, ext_p_q;
	reg [3:0] en_s1_q, en_s2_q;
	reg [3:0] rst_s1_q, rst_s2_q, rst_p_q;
	reg [3:0] cap_s1_q, cap_s2_q, cap_p_q;
	reg [3:0] kill_s1_q, kill_s2_q;
	reg [3:0] presc_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_s1_q <= 4'h0;
			ext_s2_q <= 4'h0;
			ext_p_q <= 4'h0;
			en_s1_q <= 4'h0;
			en_s2_q <= 4'h0;
			rst_s1_q <= 4'h0;
			rst_s2_q <= 4'h0;
			rst_p_q <= 4'h0;
			cap_s1_q <= 4'h0;
			cap_s2_q <= 4'h0;
			cap_p_q <= 4'h0;
			kill_s1_q <= 4'h0;
			kill_s2_q <= 4'h0;
			presc_q <= 4'h0;
		end else begin
			ext_s1_q <= ext_clk_in;
			ext_s2_q <= ext_s1_q;
			ext_p_q <= ext_s2_q;
			en_s1_q <= count_en_in;
			en_s2_q <= en_s1_q;
			rst_s1_q <= cnt_reset_in;
			rst_s2_q <= rst_s1_q;
			rst_p_q <= rst_s2_q;
			cap_s1_q <= capture_in;
			cap_s2_q <= cap_s1_q;
			cap_p_q <= cap_s2_q;
			kill_s1_q <= kill_in;
			kill_s2_q <= kill_s1_q;
			presc_q <= presc_q + 4'h1;
		end
	end

	// shared divided rates as one-cycle enables
	wire tick_div4 = (presc_q[1:0] == 2'h3);
	wire tick_div16 = (presc_q == 4'hF);

	// ahb-lite: zero wait states, read data captured at the address phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			waddr_q <= 12'h000;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_q <= addr_phase && hwrite;
			if (addr_phase) begin
				waddr_q <= haddr[11:0];
			end
			if (addr_phase && !hwrite) begin
				hrdata_q <= rd_d;
			end
		end
	end

	always @* begin
		rd_d = 32'h00000000;
		if (haddr[11:7] == 5'h00) begin
			case (haddr[4:0])
				`TCPWM_OFF_CTRL: rd_d = {21'h000000, ctrl_w[haddr[6:5]]};
				`TCPWM_OFF_PERIOD: rd_d = {16'h0000, per_w[haddr[6:5]]};
				`TCPWM_OFF_COMPARE: rd_d = {16'h0000, cmpv_w[haddr[6:5]]};
				`TCPWM_OFF_COUNT: rd_d = {16'h0000, cnt_w[haddr[6:5]]};
				`TCPWM_OFF_CAPTURE: rd_d = {16'h0000, cap_w[haddr[6:5]]};
				`TCPWM_OFF_DEADBAND: rd_d = {24'h000000, db_w[haddr[6:5]]};
				`TCPWM_OFF_INT_STATUS: rd_d = {29'h00000000, st_w[haddr[6:5]]};
				`TCPWM_OFF_INT_MASK: rd_d = {29'h00000000, msk_w[haddr[6:5]]};
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			// counter control states, one-hot
			localparam [2:0] ST_IDLE = 3'h1;
			localparam [2:0] ST_RUN = 3'h2;
			localparam [2:0] ST_HALT = 3'h4;
			reg [9:0] ctrl_q;
			reg [15:0] per_q, cmpv_q, cnt_q, cap_q;
			reg [7:0] db_q, dbc_q;
			reg [2:0] st_q, msk_q;
			reg [2:0] state_q, state_d;
			reg en_p_q, raw_q, tc_q, p_q, n_q, irq_q;
			reg tick;
			wire [1:0] mode = ctrl_q[`TCPWM_CTRL_MODE_MSB:`TCPWM_CTRL_MODE_LSB];
			wire enable = ctrl_q[`TCPWM_CTRL_ENABLE];
			wire start = enable && !en_p_q;
			wire rst_ev = rst_s2_q[i] && !rst_p_q[i];
			wire cap_ev = cap_s2_q[i] && !cap_p_q[i];
			wire cnt_ok;
			wire at_zero = (cnt_q == 16'h0000);
			wire raw_d;
			wire [2:0] ev;
			wire [2:0] clr;
			wire running = (state_q == ST_RUN);
			// one write strobe per writable register of this instance
			wire wr_ctrl = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_CTRL);
			wire wr_per = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_PERIOD);
			wire wr_cmp = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_COMPARE);
			wire wr_db = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_DEADBAND);
			wire wr_msk = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_INT_MASK);
			wire wr_st = wr_q && sel_hit(waddr_q, i, `TCPWM_OFF_INT_STATUS);

			always @* begin
				case (ctrl_q[`TCPWM_CTRL_CLK_MSB:`TCPWM_CTRL_CLK_LSB])
					`TCPWM_CLK_SYS: tick = 1'b1;
					`TCPWM_CLK_DIV4: tick = tick_div4;
					`TCPWM_CLK_DIV16: tick = tick_div16;
					`TCPWM_CLK_EXT: tick = ext_s2_q[i] && !ext_p_q[i];
					default: tick = 1'b0;
				endcase
			end

			// gated mode needs the enable input as well
			assign cnt_ok = running && enable && tick && (mode != `TCPWM_MODE_GATED || en_s2_q[i]);
			assign raw_d = rel_true(cnt_q, cmpv_q, ctrl_q[`TCPWM_CTRL_REL_MSB:`TCPWM_CTRL_REL_LSB]);
			assign ev = {cap_ev, raw_d && !raw_q, cnt_ok && at_zero};
			assign clr = wr_st ? hwdata[2:0] : 3'h0;

			// stopped while disabled; a one-shot halts at the end of its period until restarted
			always @* begin
				case (state_q)
					ST_IDLE: begin
						state_d = start ? ST_RUN : ST_IDLE;
					end
					ST_RUN: begin
						if (!enable) begin
							state_d = ST_IDLE;
						end else if (cnt_ok && at_zero && !rst_ev && mode == `TCPWM_MODE_ONESHOT) begin
							state_d = ST_HALT;
						end else begin
							state_d = ST_RUN;
						end
					end
					ST_HALT: begin
						if (!enable) begin
							state_d = ST_IDLE;
						end else if (rst_ev) begin
							state_d = ST_RUN;
						end else begin
							state_d = ST_HALT;
						end
					end
					default: begin
						state_d = ST_IDLE;
					end
				endcase
			end

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					ctrl_q <= `TCPWM_RST_CTRL;
					per_q <= `TCPWM_RST_PERIOD;
					cmpv_q <= `TCPWM_RST_COMPARE;
					db_q <= `TCPWM_RST_DEADBAND;
					msk_q <= `TCPWM_RST_MASK;
					st_q <= 3'h0;
					irq_q <= 1'b0;
				end else begin
					if (wr_ctrl) begin
						ctrl_q <= hwdata[9:0];
					end
					if (wr_per) begin
						per_q <= hwdata[15:0];
					end
					if (wr_cmp) begin
						cmpv_q <= hwdata[15:0];
					end
					if (wr_db) begin
						db_q <= hwdata[7:0];
					end
					if (wr_msk) begin
						msk_q <= hwdata[2:0];
					end
					// an event in the clearing cycle survives
					st_q <= (st_q & ~clr) | ev;
					// registered so the interrupt line has no combinational path
					irq_q <= |(st_q & msk_q);
				end
			end

			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					cnt_q <= `TCPWM_RST_PERIOD;
					cap_q <= 16'h0000;
					state_q <= ST_IDLE;
					en_p_q <= 1'b0;
					tc_q <= 1'b0;
				end else begin
					en_p_q <= enable;
					state_q <= state_d;
					tc_q <= cnt_ok && at_zero;
					if (cap_ev) begin
						cap_q <= cnt_q;
					end
					if (enable && (start || rst_ev)) begin
						cnt_q <= per_q;
					end else if (cnt_ok) begin
						if (at_zero) begin
							cnt_q <= per_q;
						end else begin
							cnt_q <= cnt_q - 16'h0001;
						end
					end
				end
			end

			// deadband: both outputs off for db_q + 1 cycles after each compare edge
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					raw_q <= 1'b0;
					dbc_q <= 8'h00;
					p_q <= 1'b0;
					n_q <= 1'b0;
				end else begin
					raw_q <= raw_d;
					if (raw_d != raw_q) begin
						dbc_q <= db_q;
					end else if (dbc_q != 8'h00) begin
						dbc_q <= dbc_q - 8'h01;
					end
					if (kill_s2_q[i]) begin
						p_q <= 1'b0;
						n_q <= 1'b0;
					end else begin
						p_q <= raw_q && (dbc_q == 8'h00) && (raw_d == raw_q);
						n_q <= !raw_q && (dbc_q == 8'h00) && (raw_d == raw_q) &&
							ctrl_q[`TCPWM_CTRL_COMPL];
					end
				end
			end

			assign ctrl_w[i] = {running, 1'b0, ctrl_q[8:0]};
			assign per_w[i] = per_q;
			assign cmpv_w[i] = cmpv_q;
			assign cnt_w[i] = cnt_q;
			assign cap_w[i] = cap_q;
			assign db_w[i] = db_q;
			assign st_w[i] = st_q;
			assign msk_w[i] = msk_q;
			assign compare_out[i] = p_q;
			assign compare_n_out[i] = n_q;
			assign tc_out[i] = tc_q;
			assign irq_out[i] = irq_q;
		end
	endgenerate

endmodule // tcpwm_top

// file: tcpwm_regs.vh
`ifndef TCPWM_REGS_VH
`define TCPWM_REGS_VH

// register byte offsets inside one instance window
`define TCPWM_OFF_CTRL 5'h00
`define TCPWM_OFF_PERIOD 5'h04
`define TCPWM_OFF_COMPARE 5'h08
`define TCPWM_OFF_COUNT 5'h0C
`define TCPWM_OFF_CAPTURE 5'h10
`define TCPWM_OFF_DEADBAND 5'h14
`define TCPWM_OFF_INT_STATUS 5'h18
`define TCPWM_OFF_INT_MASK 5'h1C

// instance window: haddr[6:5] selects the instance, haddr[11:7] must be zero
`define TCPWM_CH_LSB 5
`define TCPWM_CH_MSB 6

// control register fields
`define TCPWM_CTRL_W 11
`define TCPWM_CTRL_ENABLE 0
`define TCPWM_CTRL_MODE_LSB 1
`define TCPWM_CTRL_MODE_MSB 2
`define TCPWM_CTRL_REL_LSB 3
`define TCPWM_CTRL_REL_MSB 5
`define TCPWM_CTRL_CLK_LSB 6
`define TCPWM_CTRL_CLK_MSB 7
`define TCPWM_CTRL_COMPL 8
`define TCPWM_CTRL_RUNNING 10

// modes
`define TCPWM_MODE_FREE 2'h0
`define TCPWM_MODE_ONESHOT 2'h1
`define TCPWM_MODE_GATED 2'h2

// comparator relations
`define TCPWM_REL_LESS 3'h0
`define TCPWM_REL_LESS_OR_EQUAL 3'h1
`define TCPWM_REL_MATCH_SAME 3'h2
`define TCPWM_REL_GREATER_OR_SAME 3'h3
`define TCPWM_REL_GREATER 3'h4

// clock sources
`define TCPWM_CLK_SYS 2'h0
`define TCPWM_CLK_DIV4 2'h1
`define TCPWM_CLK_DIV16 2'h2
`define TCPWM_CLK_EXT 2'h3

// interrupt status bits
`define TCPWM_INT_TC 0
`define TCPWM_INT_CMP 1
`define TCPWM_INT_CAP 2

// reset values
`define TCPWM_RST_CTRL 10'h000
`define TCPWM_RST_PERIOD 16'hFFFF
`define TCPWM_RST_COMPARE 16'h8000
`define TCPWM_RST_DEADBAND 8'h00
`define TCPWM_RST_MASK 3'h0

`endif

// file: tcpwm_props.sv
`timescale 1ns/1ps
module tcpwm_props (
	// clock and reset
	input wire hclk,
	input wire hresetn,
	// bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// routing
	input wire [3:0] kill_in,
	input wire [3:0] compare_out,
	input wire [3:0] compare_n_out,
	input wire [3:0] tc_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd = hsel && hready && htrans[1] && !hwrite;
	property p_ok; hreadyout && !hresp; endproperty
	a_ok: assert property (p_ok) else $error("bus answer wrong");
	property p_kill0; kill_in[0] [*4] |-> !compare_out[0] && !compare_n_out[0]; endproperty
	a_kill0: assert property (p_kill0) else $error("kill 0 ignored");
	property p_kill1; kill_in[1] [*4] |-> !compare_out[1] && !compare_n_out[1]; endproperty
	a_kill1: assert property (p_kill1) else $error("kill 1 ignored");
	property p_tc; tc_out[0] |=> !tc_out[0] [*2]; endproperty
	a_tc: assert property (p_tc) else $error("tc too long");
	property p_pair; (compare_out & compare_n_out) == 4'h0; endproperty
	a_pair: assert property (p_pair) else $error("pair overlap");
	property p_gap; $fell(compare_n_out[0]) |-> !compare_out[0]; endproperty
	a_gap: assert property (p_gap) else $error("no deadband gap");
	property p_unmap; rd && haddr[11:7] != 5'h00 |=> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold; !rd |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	cover property (tc_out[0]);
	cover property (kill_in[0] [*4]);
	cover property ($rose(compare_out[0]));
endmodule // tcpwm_props
bind tcpwm_top tcpwm_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .kill_in, .compare_out, .compare_n_out, .tc_out);

// file: tcpwm_fabric.sv
`timescale 1ns/1ps
module tcpwm_fabric (
	// clock
	input wire hclk,
	// burst request per instance
	input wire [3:0] go,
	// count clocks toward the block
	output reg [3:0] ext_clk_in
);
	reg [1:0] ph_q = 2'h0;
	initial ext_clk_in = 4'h0;
	// low outside bursts; two cycles high, two low
	always @(posedge hclk) begin
		ph_q <= (go != 4'h0) ? ph_q + 2'h1 : 2'h0;
		ext_clk_in <= go & {4{ph_q[1]}};
	end
endmodule // tcpwm_fabric

// file: tcpwm_top_tb.sv
`timescale 1ns/1ps
`define CHK(w, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", w, e, s); end end
module tcpwm_top_tb;
	reg hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	reg [1:0] htrans = 2'h0;
	reg [31:0] haddr = 32'h0, hwdata = 32'h0, r;
	reg [3:0] go = 4'h0, count_en_in = 4'h0, cnt_reset_in = 4'h0, capture_in = 4'h0, kill_in = 4'h0;
	wire [31:0] hrdata;
	wire hreadyout, hresp;
	wire [3:0] ext_clk_in, compare_out, compare_n_out, tc_out, irq_out;
	integer num_errors = 0, compares = 0, n, i, t;
	always #2 hclk = ~hclk;
	tcpwm_fabric fab (.hclk, .go, .ext_clk_in);
	tcpwm_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .ext_clk_in, .count_en_in, .cnt_reset_in, .capture_in, .kill_in,
		.compare_out, .compare_n_out, .tc_out, .irq_out);
	task print_verdict;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task fail;
		num_errors++;
		print_verdict;
	endtask
	task hw;
		integer k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (k >= 20)
			fail;
	endtask
	// address phase, then data phase; read data taken at its closing edge
	task bus(input [31:0] a, input w, input [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hw;
		htrans <= 2'h0;
		hwdata <= d;
		hw;
		r = hrdata;
	endtask
	task wr(input [31:0] a, input [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task rc(input [31:0] a, input [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK("register", e, r)
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge hclk);
	endtask
	task tcw(input integer b, output integer k);
		k = 0;
		while (tc_out[b] !== 1'b1 && k < 200) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 200)
			fail;
	endtask
	function [31:0] ctl(input [1:0] m, input [2:0] rl, input [1:0] ck);
		ctl = {23'h0, 1'b1, ck, rl, m, 1'b1};
	endfunction
	function relf(input [15:0] c, input [15:0] p, input [2:0] rl);
		case (rl)
			3'h0: relf = c < p;
			3'h1: relf = c <= p;
			3'h2: relf = c == p;
			3'h3: relf = c >= p;
			3'h4: relf = c > p;
			default: relf = 1'b0;
		endcase
	endfunction
	initial begin
		#200000;
		fail;
	end
	initial begin
		cyc(10);
		hresetn <= 1'b1;
		rc(32'h44, 32'hFFFF);
		rc(32'h48, 32'h8000);
		rc(32'h80, 32'h0);
		for (n = 0; n < 4; n++) begin
			wr(n * 32 + 4, 4 + n);
			wr(n * 32 + 28, 32'h1);
			wr(n * 32, ctl(2'h0, 3'h0, 2'(n % 3)));
			tcw(n, t);
			cyc(1);
			tcw(n, t);
			`CHK("tc gap", (5 + n) * (1 << (2 * (n % 3))) - 1, t)
			`CHK("irq", 1'b1, irq_out[n])
			wr(n * 32, 32'h0);
		end
		wr(32'h18, 32'h7);
		wr(32'h4, 32'hA);
		wr(32'h14, 32'h2);
		wr(32'h8, 32'h5);
		wr(32'h0, ctl(2'h1, 3'h0, 2'h0));
		tcw(0, t);
		cyc(20);
		rc(32'h0, ctl(2'h1, 3'h0, 2'h0));
		rc(32'hC, 32'hA);
		rc(32'h18, 32'h3);
		wr(32'h18, 32'h1);
		rc(32'h18, 32'h2);
		`CHK("irq", 1'b0, irq_out[0])
		for (i = 0; i < 5; i++)
			for (t = 9; t < 12; t++) begin
				wr(32'h8, t);
				wr(32'h0, ctl(2'h1, 3'(i), 2'h0));
				cyc(10);
				`CHK("cmp", relf(16'hA, 16'(t), 3'(i)), compare_out[0])
				`CHK("cmp_n", ~relf(16'hA, 16'(t), 3'(i)), compare_n_out[0])
			end
		kill_in <= 4'h3;
		cyc(6);
		`CHK("kill", 2'h0, {compare_out[0], compare_n_out[0]})
		kill_in <= 4'h0;
		wr(32'h8, 32'h9);
		cyc(4);
		`CHK("deadband", 2'h0, {compare_out[0], compare_n_out[0]})
		cyc(1);
		`CHK("deadband end", 2'h2, {compare_out[0], compare_n_out[0]})
		wr(32'h24, 32'hA5C3);
		wr(32'h3C, 32'h4);
		wr(32'h20, ctl(2'h0, 3'h0, 2'h3));
		wr(32'h38, 32'h7);
		`CHK("irq", 1'b0, irq_out[1])
		go <= 4'h2;
		cyc(16);
		go <= 4'h0;
		cyc(6);
		rc(32'h2C, 32'hA5BF);
		capture_in <= 4'h2;
		cyc(3);
		capture_in <= 4'h0;
		cyc(4);
		rc(32'h30, 32'hA5BF);
		`CHK("irq", 1'b1, irq_out[1])
		cnt_reset_in <= 4'h2;
		cyc(3);
		cnt_reset_in <= 4'h0;
		cyc(4);
		rc(32'h2C, 32'hA5C3);
		wr(32'h20, 32'h0);
		wr(32'h20, ctl(2'h2, 3'h0, 2'h0));
		cyc(10);
		rc(32'h2C, 32'hA5C3);
		count_en_in <= 4'h2;
		cyc(10);
		count_en_in <= 4'h0;
		cyc(5);
		rc(32'h2C, 32'hA5B9);
		print_verdict;
	end
endmodule // tcpwm_top_tb
